// ===== core/bss_deglitch.sv
// Fault comparator filter: flags a level held longer than the deglitch time
`timescale 1ns/1ps
module bss_deglitch
	import bss_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_clear,
	input wire logic i_level,
	output logic o_fault
);
	logic [DG_W-1:0] cnt_reg;
	logic [DG_W-1:0] cnt_next;
	logic fault_reg;
	logic fault_next;

	always_comb
	begin
		cnt_next = '0;
		fault_next = 1'b0;
		if (!i_clear && i_level)
		begin
			// Strictly longer than the window; then held until the level drops
			if (fault_reg || cnt_reg > DG_W'(DEGLITCH_CYCLES))
			begin
				fault_next = 1'b1;
				cnt_next = cnt_reg;
			end
			else
				cnt_next = cnt_reg + DG_W'(1);
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			cnt_reg <= '0;
			fault_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			fault_reg <= fault_next;
		end
	end

	assign o_fault = fault_reg;
endmodule

// ===== core/bss_sequencer.sv
// Start-up, soft-start and output-ok sequencer of a two-phase boost controller
// Functional notes
// - Stay shut down until turn-on input high
// - Wait for supply rail threshold before initialising
// - Calibrate 195 us, latch mode select pins
// - Wait oscillator lock before phase clock toggles
// - Prebias ramp pin 50 us before ramp
// - Drivers enabled, switch only after offset exceeded
// - One-way conduction forced throughout soft-start ramp
// - Ramp complete needs clamp reached and tracking
// - One-way mode: output ok 0.5 ms later
// - Continuous mode: 100 ms delay, on-time ramps up
// - Turn-on low clears faults, turns all off
// - Open-drain output ok only within window
// - Output ok low during whole soft-start
// - Fault held over 10 us pulls ok low
// - Fault recovery releases output ok after 0.5 ms
// - Lost sync clock: lock fault, hiccup or latch
`timescale 1ns/1ps
module bss_sequencer
	import bss_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_turn_on_above,
	input wire logic i_supply_rail_ok,
	input wire logic i_fault_response_select,
	input wire logic i_light_load_select,
	input wire logic i_track_type_select,
	input wire logic i_osc_locked,
	input wire logic i_sync_clock_lost,
	input wire logic i_comp_above_offset,
	input wire logic i_ramp_at_clamp,
	input wire logic i_tracking_reference_ok,
	input wire logic i_feedback_in_window,
	input wire logic i_feedback_undervoltage,
	input wire logic i_feedback_overvoltage,
	input wire logic i_input_overvoltage,
	output bss_pkg::bss_state_e o_state,
	output logic o_fault_response_latched,
	output logic o_one_way_conduction,
	output logic o_track_type_latched,
	output logic o_phase_clock_enable,
	output logic o_ramp_prebias,
	output logic o_ramp_enable,
	output logic o_drivers_enable,
	output logic o_drivers_switching,
	output logic o_ramp_complete,
	output logic [7:0] o_high_side_gate_ontime,
	output logic o_lock_fault,
	output logic o_output_ok_flag_out,
	output logic o_output_ok_flag_oe_n
);
	bss_state_e state_reg;
	bss_state_e state_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic fresp_reg;
	logic fresp_next;
	logic light_reg;
	logic light_next;
	logic track_reg;
	logic track_next;
	logic lockf_reg;
	logic lockf_next;
	logic switch_reg;
	logic switch_next;
	logic done_reg;
	logic done_next;
	logic [ONTIME_W-1:0] ontime_reg;
	logic [ONTIME_W-1:0] ontime_next;
	logic [15:0] step_reg;
	logic [15:0] step_next;
	logic ok_reg;
	logic ok_next;
	logic enabled;
	logic uv_f;
	logic ov_f;
	logic iov_f;
	logic any_fault;
	logic [CNT_W-1:0] ok_delay;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_resetn);

	assign enabled = i_turn_on_above && i_supply_rail_ok;

	bss_deglitch u_dg_uv (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_clear(!enabled),
		.i_level(i_feedback_undervoltage),
		.o_fault(uv_f)
	);
	bss_deglitch u_dg_ov (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_clear(!enabled),
		.i_level(i_feedback_overvoltage),
		.o_fault(ov_f)
	);
	bss_deglitch u_dg_iov (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_clear(!enabled),
		.i_level(i_input_overvoltage),
		.o_fault(iov_f)
	);
	assign any_fault = uv_f || ov_f || iov_f;
	assign ok_delay = light_reg ? CNT_W'(OK_LONG_CYCLES) : CNT_W'(OK_SHORT_CYCLES);

	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		fresp_next = fresp_reg;
		light_next = light_reg;
		track_next = track_reg;
		lockf_next = lockf_reg;
		switch_next = switch_reg;
		done_next = done_reg;
		ontime_next = ontime_reg;
		step_next = step_reg;
		ok_next = 1'b0;
		if (!enabled)
		begin
			// Turn-on low clears everything and drops to shutdown
			state_next = BSS_OFF;
			cnt_next = '0;
			fresp_next = RST_FAULT_RESP;
			light_next = RST_LIGHT_LOAD;
			track_next = RST_TRACK_TYPE;
			lockf_next = 1'b0;
			switch_next = 1'b0;
			done_next = 1'b0;
			ontime_next = '0;
			step_next = '0;
		end
		else
		begin
			unique case (state_reg)
				BSS_OFF:
				begin
					state_next = BSS_CAL;
					cnt_next = '0;
				end
				BSS_CAL:
				begin
					cnt_next = cnt_reg + CNT_W'(1);
					if (cnt_reg == CNT_W'(CAL_CYCLES - 1))
					begin
						fresp_next = i_fault_response_select;
						light_next = i_light_load_select;
						track_next = i_track_type_select;
						cnt_next = '0;
						state_next = BSS_LOCK;
					end
				end
				BSS_LOCK:
					if (i_osc_locked)
						state_next = BSS_PREBIAS;
				BSS_PREBIAS:
				begin
					cnt_next = cnt_reg + CNT_W'(1);
					if (cnt_reg == CNT_W'(PREBIAS_CYCLES - 1))
					begin
						cnt_next = '0;
						state_next = BSS_RAMP;
					end
				end
				BSS_RAMP:
				begin
					if (i_comp_above_offset)
						switch_next = 1'b1;
					if (i_ramp_at_clamp && i_tracking_reference_ok)
					begin
						done_next = 1'b1;
						cnt_next = '0;
						state_next = BSS_DELAY;
					end
				end
				BSS_DELAY:
				begin
					cnt_next = cnt_reg + CNT_W'(1);
					// Gradual on-time growth, one step per 1/256 of the delay
					step_next = step_reg + 16'h0001;
					if (light_reg && step_reg == 16'(OK_LONG_CYCLES / 256 - 1))
					begin
						step_next = '0;
						if (ontime_reg != 8'hff)
							ontime_next = ontime_reg + 8'h01;
					end
					if (cnt_reg == ok_delay - CNT_W'(1))
					begin
						ontime_next = 8'hff;
						cnt_next = '0;
						state_next = BSS_RUN;
					end
				end
				BSS_RUN:
				begin
					if (any_fault)
						cnt_next = '0;
					else if (cnt_reg != CNT_W'(OK_SHORT_CYCLES))
						cnt_next = cnt_reg + CNT_W'(1);
				end
				BSS_FAULT:
				begin
					// Hiccup restarts; latch-off waits for turn-on low
					if (!fresp_reg)
					begin
						lockf_next = 1'b0;
						switch_next = 1'b0;
						done_next = 1'b0;
						ontime_next = '0;
						step_next = '0;
						cnt_next = '0;
						state_next = BSS_CAL;
					end
				end
			endcase
			if (i_sync_clock_lost && (state_reg == BSS_PREBIAS || state_reg == BSS_RAMP ||
				state_reg == BSS_DELAY || state_reg == BSS_RUN))
			begin
				lockf_next = 1'b1;
				switch_next = 1'b0;
				state_next = BSS_FAULT;
			end
		end
		// Released only after delay, in window, fault free and recovered
		if (state_next == BSS_RUN && state_reg == BSS_RUN && !any_fault &&
			i_feedback_in_window && cnt_reg == CNT_W'(OK_SHORT_CYCLES))
			ok_next = 1'b1;
		if (state_reg == BSS_DELAY && state_next == BSS_RUN)
			ok_next = !any_fault && i_feedback_in_window;
		if (state_reg == BSS_DELAY && state_next == BSS_RUN)
			cnt_next = CNT_W'(OK_SHORT_CYCLES);
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state_reg <= BSS_OFF;
			cnt_reg <= '0;
			fresp_reg <= RST_FAULT_RESP;
			light_reg <= RST_LIGHT_LOAD;
			track_reg <= RST_TRACK_TYPE;
			lockf_reg <= 1'b0;
			switch_reg <= 1'b0;
			done_reg <= 1'b0;
			ontime_reg <= '0;
			step_reg <= '0;
			ok_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			fresp_reg <= fresp_next;
			light_reg <= light_next;
			track_reg <= track_next;
			lockf_reg <= lockf_next;
			switch_reg <= switch_next;
			done_reg <= done_next;
			ontime_reg <= ontime_next;
			step_reg <= step_next;
			ok_reg <= ok_next;
		end
	end

	// Control outputs registered, decoded from next state (state_next, light_next)
	logic pclk_reg;
	logic prebias_reg;
	logic rampen_reg;
	logic drven_reg;
	logic oneway_reg;
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			pclk_reg <= 1'b0;
			prebias_reg <= 1'b0;
			rampen_reg <= 1'b0;
			drven_reg <= 1'b0;
			oneway_reg <= 1'b1;
		end
		else
		begin
			pclk_reg <= state_next inside {BSS_PREBIAS, BSS_RAMP, BSS_DELAY, BSS_RUN};
			prebias_reg <= state_next == BSS_PREBIAS;
			rampen_reg <= state_next inside {BSS_RAMP, BSS_DELAY, BSS_RUN};
			drven_reg <= state_next inside {BSS_RAMP, BSS_DELAY, BSS_RUN};
			oneway_reg <= (state_next != BSS_RUN) || !light_next;
		end
	end

	assign o_state = state_reg;
	assign o_fault_response_latched = fresp_reg;
	assign o_one_way_conduction = oneway_reg;
	assign o_track_type_latched = track_reg;
	assign o_phase_clock_enable = pclk_reg;
	assign o_ramp_prebias = prebias_reg;
	assign o_ramp_enable = rampen_reg;
	assign o_drivers_enable = drven_reg;
	assign o_drivers_switching = switch_reg;
	assign o_ramp_complete = done_reg;
	assign o_high_side_gate_ontime = ontime_reg;
	assign o_lock_fault = lockf_reg;
	assign o_output_ok_flag_out = 1'b0;
	// Open drain: enable is low while the pin is pulled low, high only when ok
	assign o_output_ok_flag_oe_n = ok_reg;

	property p_shutdown;
		!i_turn_on_above |=> state_reg == BSS_OFF && !lockf_reg && !done_reg;
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("not shut down");
	property p_supply;
		!i_supply_rail_ok |=> state_reg == BSS_OFF;
	endproperty
	a_supply: assert property (p_supply) else $error("ran without supply");
	property p_cal_len;
		$rose(state_reg == BSS_LOCK) |->
			$past(state_reg) == BSS_CAL && $past(cnt_reg) == CNT_W'(CAL_CYCLES - 1);
	endproperty
	a_cal_len: assert property (p_cal_len) else $error("calibration count wrong");
	property p_lock;
		(state_reg == BSS_LOCK && !i_osc_locked) |=> !pclk_reg;
	endproperty
	a_lock: assert property (p_lock) else $error("clock before lock");
	property p_switch;
		switch_reg |-> drven_reg;
	endproperty
	a_switch: assert property (p_switch) else $error("switching without drivers");
	property p_oneway;
		(state_reg == BSS_RAMP) |-> oneway_reg;
	endproperty
	a_oneway: assert property (p_oneway) else $error("two-way conduction in ramp");
	property p_done;
		$rose(done_reg) |-> $past(i_ramp_at_clamp && i_tracking_reference_ok);
	endproperty
	a_done: assert property (p_done) else $error("ramp complete without cause");
	property p_ok_soft;
		(state_reg != BSS_RUN) |-> !ok_reg;
	endproperty
	a_ok_soft: assert property (p_ok_soft) else $error("ok released early");
	property p_fault_pull;
		any_fault |=> !ok_reg;
	endproperty
	a_fault_pull: assert property (p_fault_pull) else $error("ok during fault");
endmodule

// ===== dv/boost_startup_sequencer_test.sv
// Self-checking bench for the start-up sequencer
`timescale 1ns/1ps
module boost_startup_sequencer_test;
	import bss_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic en = 1'b0, sup = 1'b0, fr = 1'b0, ll = 1'b0, tt = 1'b0, slost = 1'b0;
	logic comp = 1'b0, clamp = 1'b0, trk = 1'b0, win = 1'b1;
	logic [2:0] flt = 3'h0;
	logic on_above, locked, f_out, f_oe_n, wire_ok;
	logic fr_l, one_way, tt_l, pclk_en, prebias, ramp_en, drv_en, drv_sw, rdone, lock_f;
	logic [7:0] ontime;
	bss_state_e st;
	int n_errors = 0;
	int tests_run = 0;
	always #50 clk = ~clk;
	bss_partner part (.i_ref_clk(clk), .i_resetn(rstn), .i_turn_on_cmd(en),
		.i_flag_out(f_out), .i_flag_oe_n(f_oe_n), .o_turn_on_above(on_above),
		.o_osc_locked(locked), .o_flag_wire(wire_ok));
	bss_sequencer uut (.i_ref_clk(clk), .i_resetn(rstn), .i_turn_on_above(on_above),
		.i_supply_rail_ok(sup), .i_fault_response_select(fr), .i_light_load_select(ll),
		.i_track_type_select(tt), .i_osc_locked(locked), .i_sync_clock_lost(slost),
		.i_comp_above_offset(comp), .i_ramp_at_clamp(clamp), .i_tracking_reference_ok(trk),
		.i_feedback_in_window(win), .i_feedback_undervoltage(flt[0]),
		.i_feedback_overvoltage(flt[1]), .i_input_overvoltage(flt[2]), .o_state(st),
		.o_fault_response_latched(fr_l), .o_one_way_conduction(one_way),
		.o_track_type_latched(tt_l), .o_phase_clock_enable(pclk_en), .o_ramp_prebias(prebias),
		.o_ramp_enable(ramp_en), .o_drivers_enable(drv_en), .o_drivers_switching(drv_sw),
		.o_ramp_complete(rdone), .o_high_side_gate_ontime(ontime), .o_lock_fault(lock_f),
		.o_output_ok_flag_out(f_out), .o_output_ok_flag_oe_n(f_oe_n));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string what, input logic seen, input logic exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_st(input bss_state_e s);
		int k;
		k = 0;
		while (st !== s && k < 3000)
		begin
			tick(1);
			k++;
		end
		chk("state reached", st === s, 1'b1);
	endtask
	// Cycles spent in the current state before it moves on
	task automatic span(input bss_state_e s, output int n);
		n = 0;
		while (st === s && n < 20000)
		begin
			tick(1);
			n++;
		end
	endtask
	task automatic bring_up(input logic l, input logic f, input logic t);
		int n;
		{ll, fr, tt} = {l, f, t};
		{comp, clamp, trk, win} = 4'h1;
		en = 1'b1;
		sup = 1'b1;
		wait_st(BSS_CAL);
		span(BSS_CAL, n);
		chk("cal_length", n == CAL_CYCLES, 1'b1);
		chk("in_lock", st === BSS_LOCK, 1'b1);
		chk("fr_latched", fr_l, f);
		chk("tt_latched", tt_l, t);
		chk("pclk_before_lock", pclk_en, 1'b0);
		{ll, fr, tt} = ~{l, f, t};
		wait_st(BSS_PREBIAS);
		chk("pclk_after_lock", pclk_en, 1'b1);
		chk("prebias", prebias, 1'b1);
		chk("ramp_held", ramp_en, 1'b0);
		chk("fr_held", fr_l, f);
		span(BSS_PREBIAS, n);
		chk("prebias_length", n == PREBIAS_CYCLES, 1'b1);
		chk("drivers_on", drv_en, 1'b1);
		chk("ramp_on", ramp_en, 1'b1);
		chk("not_switching", drv_sw, 1'b0);
		chk("one_way_ramp", one_way, 1'b1);
		chk("flag_ramp", wire_ok, 1'b0);
		comp = 1'b1;
		tick(3);
		chk("switching", drv_sw, 1'b1);
		clamp = 1'b1;
		tick(5);
		chk("no_done_without_track", rdone, 1'b0);
		trk = 1'b1;
		wait_st(BSS_DELAY);
		chk("ramp_done", rdone, 1'b1);
		chk("flag_delay", wire_ok, 1'b0);
	endtask
	task automatic t_shutdown();
		{en, sup} = 2'b01;
		tick(30);
		chk("off_no_turn_on", st === BSS_OFF, 1'b1);
		{en, sup} = 2'b10;
		tick(30);
		chk("off_no_supply", st === BSS_OFF, 1'b1);
		sup = 1'b1;
		wait_st(BSS_CAL);
		tick(100);
		sup = 1'b0;
		tick(3);
		chk("supply_drop", st === BSS_OFF, 1'b1);
		en = 1'b0;
		tick(3);
		$display("test shutdown done");
	endtask
	task automatic t_one_way();
		int n;
		bring_up(1'b0, 1'b0, 1'b1);
		span(BSS_DELAY, n);
		chk("short_delay", n == OK_SHORT_CYCLES, 1'b1);
		chk("run", st === BSS_RUN, 1'b1);
		chk("flag_released", wire_ok, 1'b1);
		$display("test one-way start done");
	endtask
	task automatic t_faults();
		for (int i = 0; i < 3; i++)
		begin
			flt = 3'h1 << i;
			tick(90);
			chk("flag_short_glitch", wire_ok, 1'b1);
			tick(30);
			chk("flag_fault", wire_ok, 1'b0);
			flt = 3'h0;
			tick(4900);
			chk("flag_recovering", wire_ok, 1'b0);
			tick(200);
			chk("flag_recovered", wire_ok, 1'b1);
		end
		win = 1'b0;
		tick(3);
		chk("flag_window", wire_ok, 1'b0);
		slost = 1'b1;
		tick(1);
		chk("hiccup_fault", st === BSS_FAULT, 1'b1);
		chk("hiccup_lock_fault", lock_f, 1'b1);
		chk("hiccup_no_switch", drv_sw, 1'b0);
		slost = 1'b0;
		tick(2);
		chk("hiccup_restart", st === BSS_CAL, 1'b1);
		chk("hiccup_cleared", lock_f, 1'b0);
		$display("test faults done");
	endtask
	task automatic t_disable();
		en = 1'b0;
		tick(3);
		chk("off_state", st === BSS_OFF, 1'b1);
		chk("lock_fault_cleared", lock_f, 1'b0);
		chk("drivers_off", drv_en, 1'b0);
		chk("flag_off", wire_ok, 1'b0);
		$display("test disable done");
	endtask
	task automatic t_continuous();
		logic [7:0] o0;
		bring_up(1'b1, 1'b1, 1'b0);
		o0 = ontime;
		tick(OK_SHORT_CYCLES + 100);
		chk("long_delay", st === BSS_DELAY, 1'b1);
		chk("flag_long", wire_ok, 1'b0);
		chk("ontime_rising", ontime !== o0, 1'b1);
		slost = 1'b1;
		tick(3);
		chk("lock_fault", lock_f, 1'b1);
		chk("fault_state", st === BSS_FAULT, 1'b1);
		slost = 1'b0;
		tick(10);
		chk("latched_off", st === BSS_FAULT, 1'b1);
		$display("test continuous start done");
	endtask
	// Expected run is about 31k cycles, so 100k cycles means a hang
	initial
	begin
		#10_000_000;
		n_errors++;
		$display("ERROR watchdog expected finish seen timeout");
		tally_and_finish();
	end
	initial
	begin
		tick(10);
		rstn = 1'b1;
		tick(2);
		t_shutdown();
		t_one_way();
		t_faults();
		t_disable();
		t_continuous();
		t_disable();
		tally_and_finish();
	end
endmodule

// ===== dv/bss_partner.sv
// Turn-on source, oscillator lock model and output-ok monitor wire
`timescale 1ns/1ps
module bss_partner
	import bss_pkg::*;
#(
	parameter int unsigned LOCK_DLY = 2100
)
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_turn_on_cmd,
	input wire logic i_flag_out,
	input wire logic i_flag_oe_n,
	output logic o_turn_on_above,
	output logic o_osc_locked,
	output logic o_flag_wire
);
	int unsigned lock_cnt;
	// Driving the turn-on level low is how the source disables the device
	assign o_turn_on_above = i_turn_on_cmd;
	// Pull-up on the monitor side: a released pin reads high
	assign o_flag_wire = i_flag_oe_n ? 1'b1 : i_flag_out;
	// Lock takes time after turn-on and is lost again when turned off
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			lock_cnt <= 0;
			o_osc_locked <= 1'b0;
		end
		else if (!i_turn_on_cmd)
		begin
			lock_cnt <= 0;
			o_osc_locked <= 1'b0;
		end
		else
		begin
			if (lock_cnt < LOCK_DLY)
				lock_cnt <= lock_cnt + 1;
			o_osc_locked <= (lock_cnt >= LOCK_DLY);
		end
	end
endmodule

// ===== inc/bss_pkg.sv
// Constants and types for the boost start-up sequencer
package bss_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned CAL_TIME_US = 195;
	localparam int unsigned PREBIAS_TIME_US = 50;
	localparam int unsigned FAULT_DEGLITCH_US = 10;
	localparam int unsigned OK_DELAY_SHORT_US = 500;
	localparam int unsigned OK_DELAY_LONG_US = 100_000;
	localparam int unsigned CAL_CYCLES = CAL_TIME_US * (CLK_HZ / 1_000_000);
	localparam int unsigned PREBIAS_CYCLES = PREBIAS_TIME_US * (CLK_HZ / 1_000_000);
	localparam int unsigned DEGLITCH_CYCLES = FAULT_DEGLITCH_US * (CLK_HZ / 1_000_000);
	localparam int unsigned OK_SHORT_CYCLES = OK_DELAY_SHORT_US * (CLK_HZ / 1_000_000);
	localparam int unsigned OK_LONG_CYCLES = OK_DELAY_LONG_US * (CLK_HZ / 1_000_000);
	localparam int unsigned CNT_W = 20;
	localparam int unsigned DG_W = 8;
	localparam int unsigned ONTIME_W = 8;
	// Latched mode defaults while the device is shut down
	localparam logic RST_FAULT_RESP = 1'b0;
	localparam logic RST_LIGHT_LOAD = 1'b0;
	localparam logic RST_TRACK_TYPE = 1'b0;

	typedef enum logic [2:0] {
		BSS_OFF = 3'b000,
		BSS_CAL = 3'b001,
		BSS_LOCK = 3'b011,
		BSS_PREBIAS = 3'b010,
		BSS_RAMP = 3'b110,
		BSS_DELAY = 3'b111,
		BSS_RUN = 3'b101,
		BSS_FAULT = 3'b100
	} bss_state_e;
endpackage
